// *** hdl/transient_tap_detect.sv ***
// Transient threshold debounce and tap event registers with their detector.
// Assumes the strobe register port, samples and mode inputs share one clock.
//
// What this block does
// - Filtered acceleration above threshold raises transient flag and enabled irq.
// - Threshold bit 7 picks debounce up/down or up/clear; default up/down.
// - Threshold is seven unsigned bits 6..0, 0.063 g per count, resets zero.
// - Transient range stays 8 g regardless of measurement full scale.
// - Low-noise bit caps the reachable threshold at 4 g.
// - Count register sets consecutive debounce steps before transient event.
// - Debounce step is 1.25 ms at 800 Hz, 2.5 ms at 400 Hz.
// - Slower rates step per sample, capped 20/80/160 ms; high-res 2.5 ms.
// - Tap config holds per-axis single and double enables, Z X in 5..0.
// - Abort bit clear: double tap continues despite pulse in latency.
// - Abort bit set: pulse starting and ending in latency suspends double.
// - Config bit 6 latches tap flags until the source register is read.
// - Tap event shows only when its axis and type are enabled.
// - Source: active bit 7, axes 6..4, double bit 3, polarities 2..0.
// - Double bit reads 0 for single tap, 1 for double tap.
// - Polarity bit reads 0 for positive pulse, 1 for negative.
// - Reading source clears all its bits and the tap interrupt, unless a new tap event lands in the read cycle.
`timescale 1ns/100ps
module transient_tap_detect
  import tap_transient_pkg::*;
#(
  parameter int unsigned STEP_BASE_CYCLES_P = STEP_BASE_CYCLES
)
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic sample_valid_in,
  input wire logic [2:0][7:0] hpf_accel_in,
  input wire logic [2:0][7:0] tap_accel_in,
  input wire logic [2:0] output_sample_rate_in,
  input wire logic [1:0] oversampling_mode_in,
  input wire logic low_noise_in,
  input wire logic transient_irq_enable_in,
  input wire logic [2:0][6:0] tap_threshold_in,
  input wire logic [7:0] tap_time_limit_in,
  input wire logic [7:0] tap_latency_window_in,
  input wire logic [7:0] tap_second_window_in,
  output logic transient_event_out,
  output logic transient_irq_out,
  output logic tap_irq_out
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] thr;
    logic [7:0] cnt;
    logic [7:0] cfg;
    logic [7:0] src;
    logic [7:0] rdata;
    logic [7:0] dbc;
    logic cond;
    logic trans_evt;
    logic trans_irq;
    logic [16:0] base_cnt;
    logic [9:0] mult_cnt;
    logic step_tick;
  } core_state_t;

  core_state_t s;
  core_state_t n;
  tap_if tap_bus();
  logic [9:0] mult;
  logic [6:0] eff_thr;
  logic [2:0] hit;
  logic [2:0] dbl_hit;

  function automatic logic [6:0] cap_ths(input logic [6:0] t,
                                         input logic ln);
    return (ln && t > LOW_NOISE_THS_MAX) ? LOW_NOISE_THS_MAX : t;
  endfunction

  assign mult = step_mult(output_sample_rate_in,
                          os_mode_t'(oversampling_mode_in));

  assign eff_thr = cap_ths(s.thr[THRESHOLD_MSB:0], low_noise_in);

  // ------------------------------------------------------------------
  // Tap detector hookup
  // ------------------------------------------------------------------
  assign tap_bus.sample_valid = sample_valid_in;
  assign tap_bus.step_tick = s.step_tick;
  assign tap_bus.accel = tap_accel_in;
  assign tap_bus.tmlt = tap_time_limit_in;
  assign tap_bus.ltcy = tap_latency_window_in;
  assign tap_bus.wind = tap_second_window_in;
  assign tap_bus.double_tap_abort = s.cfg[DOUBLE_ABORT_BIT];

  generate
    for (genvar g = 0; g < 3; g++) begin : g_tap_ths
      assign tap_bus.ths[g] = cap_ths(tap_threshold_in[g], low_noise_in);
      assign dbl_hit[g] = tap_bus.dbl[g] & s.cfg[2 * g + DOUBLE_EN_LSB];
      assign hit[g] = dbl_hit[g] |
                      (tap_bus.single[g] & s.cfg[2 * g + SINGLE_EN_LSB]);
    end
  endgenerate

  tap_detector u_tap_detector (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .bus(tap_bus.detector)
  );

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    n = s;
    n.step_tick = 1'b0;
    if (s.base_cnt >= 17'(STEP_BASE_CYCLES_P - 1)) begin
      n.base_cnt = 17'h00000;
      if (s.mult_cnt >= mult - 10'd1) begin
        n.mult_cnt = 10'h000;
        n.step_tick = 1'b1;
      end else begin
        n.mult_cnt = s.mult_cnt + 10'h001;
      end
    end else begin
      n.base_cnt = s.base_cnt + 17'h00001;
    end

    // data kept on the 8 g scale
    if (sample_valid_in) begin
      n.cond = 1'b0;
      for (int a = 0; a < 3; a++) begin
        if (mag8(hpf_accel_in[a]) > {1'b0, eff_thr}) n.cond = 1'b1;
      end
    end

    if (s.step_tick) begin
      if (s.cond) begin
        n.dbc = (s.dbc < s.cnt) ? s.dbc + 8'h01 : s.cnt;
        n.trans_evt = (n.dbc >= s.cnt);
      end else begin
        n.trans_evt = 1'b0;
        if (s.thr[DEBOUNCE_MODE_BIT]) n.dbc = 8'h00;
        else if (s.dbc != 8'h00) n.dbc = s.dbc - 8'h01;
      end
    end
    n.trans_irq = n.trans_evt & transient_irq_enable_in;

    if (reg_wr_in) begin
      if (reg_addr_in == ADDR_TRANS_THRESHOLD) begin
        n.thr = reg_wdata_in;
      end else if (reg_addr_in == ADDR_TRANS_COUNT) begin
        n.cnt = reg_wdata_in;
      end else if (reg_addr_in == ADDR_TAP_CONFIG) begin
        n.cfg = reg_wdata_in;
      end
    end

    if (reg_rd_in) begin
      if (reg_addr_in == ADDR_TRANS_THRESHOLD) begin
        n.rdata = s.thr;
      end else if (reg_addr_in == ADDR_TRANS_COUNT) begin
        n.rdata = s.cnt;
      end else if (reg_addr_in == ADDR_TAP_CONFIG) begin
        n.rdata = s.cfg;
      end else if (reg_addr_in == ADDR_TAP_SOURCE) begin
        n.rdata = s.src;
        n.src = TAP_SOURCE_RST;
      end else begin
        n.rdata = UNMAPPED_READ;
      end
    end

    // latched flags held
    // A new event in the read cycle still lands, so it is never lost.
    if ((|hit) && !(s.cfg[EVENT_LATCH_BIT] && n.src[EVENT_ACTIVE_BIT])) begin
      n.src[EVENT_ACTIVE_BIT] = 1'b1;
      n.src[DOUBLE_EVENT_BIT] = |dbl_hit;
      for (int a = 0; a < 3; a++) begin
        n.src[AXIS_EVENT_LSB + a] = hit[a];
        n.src[POLARITY_LSB + a] = hit[a] & tap_bus.pol[a];
      end
    end

    if (srst_in) begin
      n = '0;
      n.thr = TRANS_THRESHOLD_RST;
      n.cnt = TRANS_COUNT_RST;
      n.cfg = TAP_CONFIG_RST;
      n.src = TAP_SOURCE_RST;
    end
  end

  always_ff @(posedge core_clk_in) begin
    s <= n;
  end

  assign reg_rdata_out = s.rdata;
  assign transient_event_out = s.trans_evt;
  assign transient_irq_out = s.trans_irq;
  assign tap_irq_out = s.src[EVENT_ACTIVE_BIT];

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (srst_in);

  a_regs_reset_zero: assert property ($past(srst_in) |->
    s.thr == 8'h00 && s.cnt == 8'h00 && s.cfg == 8'h00 &&
    s.src == 8'h00)
    else $error("registers not zero after reset");

  a_low_noise_cap: assert property (low_noise_in |->
    eff_thr <= 7'h3f && tap_bus.ths[0] <= 7'h3f)
    else $error("threshold above 4 g with low noise set");

  a_trans_flag_cause: assert property ($rose(s.trans_evt) |->
    $past(s.cond) && $past(s.step_tick) && s.dbc >= s.cnt)
    else $error("transient flag without condition at a step");

  a_debounce_clear: assert property (s.thr[7] && s.step_tick && !s.cond
    |=> s.dbc == 8'h00 && !s.trans_evt)
    else $error("debounce counter not cleared in clear mode");

  a_debounce_down: assert property (!s.thr[7] && s.step_tick && !s.cond &&
    s.dbc != 8'h00 |=> s.dbc == $past(s.dbc) - 8'h01)
    else $error("debounce counter not decremented");

  a_debounce_steps: assert property (s.step_tick && s.cond &&
    ({1'b0, s.dbc} + 9'h001 < {1'b0, s.cnt}) ##1 !s.step_tick [*1]
    |-> !s.trans_evt)
    else $error("transient flag before count reached");

  a_step_fastest: assert property (output_sample_rate_in == 3'd0 |->
    mult == 10'd1)
    else $error("800 Hz step not one base unit");

  a_tap_enable_gate: assert property ($rose(s.src[7]) |->
    $past(|s.cfg[5:0]) && (|s.src[6:4]))
    else $error("tap event reported while not enabled");

  a_latch_freeze: assert property (s.src[7] && s.cfg[6] &&
    !(reg_rd_in && reg_addr_in == 8'h22) && !reg_wr_in |=>
    s.src == $past(s.src))
    else $error("latched tap source changed without a read");

  a_src_read_clear: assert property (reg_rd_in && reg_addr_in == 8'h22 &&
    !(|hit) |=> s.src == 8'h00 && !tap_irq_out &&
    reg_rdata_out == $past(s.src))
    else $error("tap source not cleared by read");

endmodule

// *** pkg/tap_transient_pkg.sv ***
// Constants, field positions and types of the transient and tap event block.
// Assumes a single 100 MHz core clock and a synchronous active-high reset.
package tap_transient_pkg;

  // ------------------------------------------------------------------
  // Register map and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_TRANS_THRESHOLD = 8'h1f;
  localparam logic [7:0] ADDR_TRANS_COUNT = 8'h20;
  localparam logic [7:0] ADDR_TAP_CONFIG = 8'h21;
  localparam logic [7:0] ADDR_TAP_SOURCE = 8'h22;
  localparam logic [7:0] TRANS_THRESHOLD_RST = 8'h00;
  localparam logic [7:0] TRANS_COUNT_RST = 8'h00;
  localparam logic [7:0] TAP_CONFIG_RST = 8'h00;
  localparam logic [7:0] TAP_SOURCE_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int DEBOUNCE_MODE_BIT = 7;
  localparam int THRESHOLD_MSB = 6;
  localparam int DOUBLE_ABORT_BIT = 7;
  localparam int EVENT_LATCH_BIT = 6;
  localparam int SINGLE_EN_LSB = 0;
  localparam int DOUBLE_EN_LSB = 1;
  localparam int EVENT_ACTIVE_BIT = 7;
  localparam int AXIS_EVENT_LSB = 4;
  localparam int DOUBLE_EVENT_BIT = 3;
  localparam int POLARITY_LSB = 0;
  // Largest threshold count, about 4 g at 0.063 g per count.
  localparam logic [6:0] LOW_NOISE_THS_MAX = 7'h3f;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_BASE_US = 1250;
  localparam int STEP_BASE_CYCLES = STEP_BASE_US * 1000 / CLK_PERIOD_NS;
  // Sample period per rate code, in 1.25 ms units: 800 Hz down to 1.56 Hz.
  localparam logic [7:0][9:0] ODR_PERIOD_STEPS = {10'd512, 10'd128, 10'd64,
    10'd16, 10'd8, 10'd4, 10'd2, 10'd1};
  localparam logic [9:0] STEP_CAP_NORMAL = 10'd16;
  localparam logic [9:0] STEP_CAP_LOW_POWER_LOW_NOISE_MODE = 10'd64;
  localparam logic [9:0] STEP_CAP_LP = 10'd128;
  localparam logic [9:0] STEP_HIGH_RESOLUTION_MODE = 10'd2;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_LOW_POWER_LOW_NOISE_MODE = 2'b01,
    MODE_HIGH_RESOLUTION_MODE = 2'b10,
    MODE_LP = 2'b11
  } os_mode_t;

  typedef enum logic [2:0] {
    TD_IDLE = 3'b000,
    TD_FIRST = 3'b001,
    TD_LATENCY = 3'b010,
    TD_WINDOW = 3'b011,
    TD_SECOND = 3'b100
  } tap_state_t;

  function automatic logic [7:0] mag8(input logic [7:0] v);
    return v[7] ? 8'(~v + 8'h01) : v;
  endfunction

  function automatic logic [9:0] step_mult(input logic [2:0] output_sample_rate,
                                           input os_mode_t mode);
    logic [9:0] per;
    per = ODR_PERIOD_STEPS[output_sample_rate];
    case (mode)
      MODE_HIGH_RESOLUTION_MODE: return (per < STEP_HIGH_RESOLUTION_MODE) ? per : STEP_HIGH_RESOLUTION_MODE;
      MODE_LOW_POWER_LOW_NOISE_MODE: return (per < STEP_CAP_LOW_POWER_LOW_NOISE_MODE) ? per : STEP_CAP_LOW_POWER_LOW_NOISE_MODE;
      MODE_LP: return (per < STEP_CAP_LP) ? per : STEP_CAP_LP;
      default: return (per < STEP_CAP_NORMAL) ? per : STEP_CAP_NORMAL;
    endcase
  endfunction

endpackage

// *** pkg/tap_if.sv ***
// Signals between the register core and the per-axis tap detector.
// Assumes both ends run on the same core clock.
`timescale 1ns/100ps
interface tap_if;
  logic sample_valid;
  logic step_tick;
  logic [2:0][7:0] accel;
  logic [2:0][6:0] ths;
  logic [7:0] tmlt;
  logic [7:0] ltcy;
  logic [7:0] wind;
  logic double_tap_abort;
  logic [2:0] single;
  logic [2:0] dbl;
  logic [2:0] pol;
  modport detector(input sample_valid, step_tick, accel, ths, tmlt, ltcy,
                   wind, double_tap_abort, output single, dbl, pol);
  modport owner(output sample_valid, step_tick, accel, ths, tmlt, ltcy,
                wind, double_tap_abort, input single, dbl, pol);
endinterface

// *** hdl/tap_detector.sv ***
// Per-axis single and double tap detector.
// Assumes samples and debounce steps arrive as one-cycle strobes on one clock.
`timescale 1ns/100ps
module tap_detector
  import tap_transient_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  tap_if.detector bus
);

  typedef struct packed {
    tap_state_t [2:0] st;
    logic [2:0][7:0] tmr;
    logic [2:0] pol;
    logic [2:0] prev;
    logic [2:0] inl;
    logic [2:0] single;
    logic [2:0] dbl;
  } det_state_t;

  det_state_t s;
  det_state_t n;
  logic [2:0] above;

  always_comb begin
    n = s;
    for (int a = 0; a < 3; a++) begin
      above[a] = mag8(bus.accel[a]) > {1'b0, bus.ths[a]};
    end
    for (int a = 0; a < 3; a++) begin
      n.single[a] = 1'b0;
      n.dbl[a] = 1'b0;
      if (bus.sample_valid) begin
        n.prev[a] = above[a];
      end
      case (s.st[a])
        TD_IDLE: begin
          if (bus.sample_valid && above[a] && !s.prev[a]) begin
            n.st[a] = TD_FIRST;
            n.tmr[a] = 8'h00;
            n.pol[a] = bus.accel[a][7];
          end
        end
        TD_FIRST: begin
          if (bus.sample_valid && !above[a]) begin
            n.single[a] = 1'b1;
            n.st[a] = TD_LATENCY;
            n.tmr[a] = 8'h00;
            n.inl[a] = 1'b0;
          end else if (bus.step_tick) begin
            if (s.tmr[a] >= bus.tmlt) n.st[a] = TD_IDLE;
            else n.tmr[a] = s.tmr[a] + 8'h01;
          end
        end
        TD_LATENCY: begin
          if (bus.sample_valid && above[a] && !s.prev[a]) begin
            n.inl[a] = 1'b1;
          end
          if (bus.double_tap_abort && bus.sample_valid && s.inl[a] && !above[a]) begin
            n.st[a] = TD_IDLE;
          end else if (bus.step_tick) begin
            if (s.tmr[a] >= bus.ltcy) begin
              n.st[a] = TD_WINDOW;
              n.tmr[a] = 8'h00;
            end else begin
              n.tmr[a] = s.tmr[a] + 8'h01;
            end
          end
        end
        TD_WINDOW: begin
          if (bus.sample_valid && above[a] && !s.prev[a]) begin
            n.st[a] = TD_SECOND;
            n.tmr[a] = 8'h00;
            n.pol[a] = bus.accel[a][7];
          end else if (bus.step_tick) begin
            if (s.tmr[a] >= bus.wind) n.st[a] = TD_IDLE;
            else n.tmr[a] = s.tmr[a] + 8'h01;
          end
        end
        TD_SECOND: begin
          if (bus.sample_valid && !above[a]) begin
            n.dbl[a] = 1'b1;
            n.st[a] = TD_IDLE;
          end else if (bus.step_tick) begin
            if (s.tmr[a] >= bus.tmlt) n.st[a] = TD_IDLE;
            else n.tmr[a] = s.tmr[a] + 8'h01;
          end
        end
        default: n.st[a] = TD_IDLE;
      endcase
    end
    if (srst_in) begin
      n = '0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    s <= n;
  end

  assign bus.single = s.single;
  assign bus.dbl = s.dbl;
  assign bus.pol = s.pol;

  a_double_abort_x: assert property (@(posedge core_clk_in)
    disable iff (srst_in)
    s.st[0] == TD_LATENCY && s.inl[0] && bus.double_tap_abort && bus.sample_valid &&
    !above[0] |=> s.st[0] == TD_IDLE && !s.dbl[0])
    else $error("double tap not aborted after short latency pulse");

endmodule

// *** test/transient_tap_detect_tb.sv ***
// Self-checking bench for the transient and tap event block.
// Assumes the strobe register port and one 100 MHz core clock.
`timescale 1ns/100ps
module transient_tap_detect_tb;
  import tap_transient_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic sample_valid_in = 1'b0;
  logic [2:0][7:0] hpf_accel_in = '0;
  logic [2:0][7:0] tap_accel_in = '0;
  logic [2:0] output_sample_rate_in = 3'h0;
  logic [1:0] oversampling_mode_in = 2'h0;
  logic low_noise_in = 1'b0;
  logic transient_irq_enable_in = 1'b1;
  logic [2:0][6:0] tap_threshold_in = {7'h0a, 7'h0a, 7'h0a};
  logic [7:0] tap_time_limit_in = 8'h08;
  logic [7:0] tap_latency_window_in = 8'h02;
  logic [7:0] tap_second_window_in = 8'h28;
  logic transient_event_out;
  logic transient_irq_out;
  logic tap_irq_out;
  int err_total = 0;
  int checks_done = 0;
  int ax;
  logic [7:0] exp_src;

  transient_tap_detect #(.STEP_BASE_CYCLES_P(4)) dut (
    .core_clk_in(core_clk_in), .srst_in(srst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .sample_valid_in(sample_valid_in),
    .hpf_accel_in(hpf_accel_in), .tap_accel_in(tap_accel_in),
    .output_sample_rate_in(output_sample_rate_in),
    .oversampling_mode_in(oversampling_mode_in),
    .low_noise_in(low_noise_in),
    .transient_irq_enable_in(transient_irq_enable_in),
    .tap_threshold_in(tap_threshold_in),
    .tap_time_limit_in(tap_time_limit_in),
    .tap_latency_window_in(tap_latency_window_in),
    .tap_second_window_in(tap_second_window_in),
    .transient_event_out(transient_event_out),
    .transient_irq_out(transient_irq_out), .tap_irq_out(tap_irq_out));

  initial begin
    forever #5 core_clk_in = ~core_clk_in;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen,
               exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    cyc(1);
    reg_wr_in = 1'b0;
  endtask

  // Read data lands on the clock edge that samples the strobe and then holds.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string what);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    cyc(1);
    reg_rd_in = 1'b0;
    cyc(1);
    check(reg_rdata_out, exp, what);
  endtask

  // The same value feeds the high-pass and the tap paths.
  task automatic sample(input logic [2:0][7:0] v);
    hpf_accel_in = v;
    tap_accel_in = v;
    sample_valid_in = 1'b1;
    cyc(1);
    sample_valid_in = 1'b0;
  endtask

  task automatic wait_event(input logic level, input string what);
    int i;
    i = 0;
    while (transient_event_out !== level && i < 60) begin
      cyc(1);
      i++;
    end
    check({7'h00, transient_event_out}, {7'h00, level}, what);
  endtask

  // A short pulse: one sample above threshold, then one back at zero.
  task automatic tap(input int axis, input logic [7:0] v);
    logic [2:0][7:0] s;
    s = '0;
    s[axis] = v;
    sample(s);
    sample('0);
  endtask

  task automatic print_verdict;
    $display("Checks %0d, errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Tests take about 1500 cycles; this bound of 20000 cycles is far beyond that.
  initial begin
    #200000;
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    cyc(12);
    srst_in = 1'b0;
    cyc(1);
    rd(ADDR_TRANS_THRESHOLD, 8'h00, "threshold reset");
    rd(ADDR_TRANS_COUNT, 8'h00, "count reset");
    rd(ADDR_TAP_CONFIG, 8'h00, "tap config reset");
    rd(ADDR_TAP_SOURCE, 8'h00, "tap source reset");
    rd(8'h55, 8'h00, "unmapped read");
    wr(ADDR_TRANS_THRESHOLD, 8'h85);
    wr(ADDR_TRANS_COUNT, 8'ha5);
    wr(ADDR_TAP_CONFIG, 8'hff);
    wr(ADDR_TAP_SOURCE, 8'h5a);
    rd(ADDR_TRANS_THRESHOLD, 8'h85, "threshold rw");
    rd(ADDR_TRANS_COUNT, 8'ha5, "count rw");
    rd(ADDR_TAP_CONFIG, 8'hff, "tap config rw");
    rd(ADDR_TAP_SOURCE, 8'h00, "source read only");
    // Transient above threshold with no debounce, then back below.
    wr(ADDR_TRANS_THRESHOLD, 8'h05);
    wr(ADDR_TRANS_COUNT, 8'h00);
    sample({8'h00, 8'h00, 8'h14});
    wait_event(1'b1, "transient raised");
    cyc(1);
    check({7'h00, transient_irq_out}, 8'h01, "transient irq");
    transient_irq_enable_in = 1'b0;
    cyc(2);
    check({7'h00, transient_irq_out}, 8'h00, "transient irq off");
    transient_irq_enable_in = 1'b1;
    sample('0);
    wait_event(1'b0, "transient cleared");
    // A negative value counts by magnitude, beyond the 4 g range.
    wr(ADDR_TRANS_THRESHOLD, 8'h7e);
    sample({8'h81, 8'h00, 8'h00});
    wait_event(1'b1, "transient full range");
    sample('0);
    wait_event(1'b0, "transient range clear");
    // Low-noise caps the reachable threshold near 4 g.
    wr(ADDR_TRANS_THRESHOLD, 8'h7f);
    sample({8'h00, 8'h50, 8'h00});
    cyc(30);
    check({7'h00, transient_event_out}, 8'h00, "below full thr");
    low_noise_in = 1'b1;
    sample({8'h00, 8'h50, 8'h00});
    wait_event(1'b1, "low noise cap");
    low_noise_in = 1'b0;
    sample('0);
    wait_event(1'b0, "low noise clear");
    // Debounce of three steps of four cycles each at 800 Hz.
    wr(ADDR_TRANS_THRESHOLD, 8'h85);
    wr(ADDR_TRANS_COUNT, 8'h03);
    sample({8'h00, 8'h00, 8'h14});
    cyc(6);
    check({7'h00, transient_event_out}, 8'h00, "debounce early");
    wait_event(1'b1, "debounce done");
    sample('0);
    wait_event(1'b0, "debounce clear");
    // Let the tap detectors run out their windows from the samples above.
    cyc(250);
    // Single taps per axis, sign alternating.
    for (ax = 0; ax < 3; ax++) begin
      wr(ADDR_TAP_CONFIG, 8'(1 << (2 * ax)));
      tap(ax, (ax == 1) ? 8'hec : 8'h14);
      cyc(4);
      exp_src = 8'h80 | 8'(1 << (4 + ax)) | ((ax == 1) ? 8'h02 : 8'h00);
      check({7'h00, tap_irq_out}, 8'h01, "tap irq set");
      rd(ADDR_TAP_SOURCE, exp_src, "single tap");
      check({7'h00, tap_irq_out}, 8'h00, "tap irq clear");
      rd(ADDR_TAP_SOURCE, 8'h00, "source cleared");
      cyc(10);
    end
    // Only the double enable set: a single tap is not reported.
    cyc(250);
    wr(ADDR_TAP_CONFIG, 8'h02);
    tap(0, 8'h14);
    cyc(250);
    rd(ADDR_TAP_SOURCE, 8'h00, "disabled single");
    // Second tap after the latency and inside the window.
    tap(0, 8'h14);
    cyc(20);
    tap(0, 8'h14);
    cyc(4);
    rd(ADDR_TAP_SOURCE, 8'h98, "double tap");
    cyc(200);
    // Abort set: a whole pulse inside a long latency suspends it.
    tap_latency_window_in = 8'h0a;
    wr(ADDR_TAP_CONFIG, 8'h82);
    tap(0, 8'h14);
    cyc(8);
    tap(0, 8'h14);
    cyc(200);
    rd(ADDR_TAP_SOURCE, 8'h00, "double aborted");
    tap_latency_window_in = 8'h02;
    // Latch on: a later event leaves the held source untouched.
    wr(ADDR_TAP_CONFIG, 8'h45);
    tap(0, 8'h14);
    cyc(10);
    tap(1, 8'hec);
    cyc(4);
    rd(ADDR_TAP_SOURCE, 8'h90, "latched source");
    rd(ADDR_TAP_SOURCE, 8'h00, "latch released");
    print_verdict();
  end
endmodule
